//--- rtl/sdram_module_command_protocol.sv
// Command decoder, bank state, mode register and burst engine of the SDRAM module.
// What this block does
// - All command, address, mask and write-data pins are taken on the rising clock.
// - ACTIVE takes the bank from bank selects, row from 12 or 13 bits.
// - READ and WRITE take address bits 0 to 9 as starting column.
// - Burst lengths 1, 2, 4, 8 or full page; terminate cuts any burst.
// - Auto precharge closes the row by itself when a burst of length 1 to 8 runs out; terminate or a new column command leaves it open.
// - A new column command is taken every cycle, even mid-burst.
// - One bank may be precharged while another bank is accessed.
// - Mode register resets to zero, flagged as not loaded, and is loaded before use.
// - Only the load-mode command writes the mode register; it holds otherwise.
// - Mode fields: length, order, latency, operating mode, write mode, reserved.
// - Programmed length bounds the locations moved by one READ or WRITE.
// - Full page is sequential only; short lengths allow both orders.
// - Bursts stay within an aligned block and wrap at its boundary.
// - Full-page bursts wrap back to the start of the row.
// - Precharge with bit 10 low closes one bank, high closes all.
// - Byte mask blocks write data and floats read lanes two clocks later.
// - Read latency is two or three clocks from command to data.
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`default_nettype none
module sdram_module_command_protocol
	import sdram_module_pkg::*;
(
	input  wire logic              CLOCK,
	input  wire logic              RSTN,
	input  wire logic [1:0]        RANK_SEL_N,
	input  wire logic              RAS_N,
	input  wire logic              CAS_N,
	input  wire logic              WE_N,
	input  wire logic              BANK_SELECT_LO,
	input  wire logic              BANK_SELECT_HI,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [LANES-1:0]  BYTE_LANE_MASK,
	input  wire logic [DQ_W-1:0]   DQ_IN,
	output logic      [DQ_W-1:0]   DQ_OUT,
	output logic      [LANES-1:0]  DQ_OE,
	input  wire logic              HSEL,
	input  wire logic [31:0]       HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic      [31:0]       HRDATA,
	output logic                   HREADYOUT,
	output logic      [1:0]        HRESP
);
	function automatic cmd_t decode_cmd(input logic [1:0] sel_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		if (&sel_n) begin
			return CMD_INHIBIT;
		end
		return cmd_t'({1'b0, ras_n, cas_n, we_n});
	endfunction

	function automatic logic [9:0] len_mask(input logic [2:0] code);
		case (code)
			BL_CODE_1:    return COL_MASK_1;
			BL_CODE_2:    return COL_MASK_2;
			BL_CODE_4:    return COL_MASK_4;
			BL_CODE_8:    return COL_MASK_8;
			BL_CODE_FULL: return COL_MASK_FULL;
			// Reserved length codes fall back to single-location access.
			default:      return COL_MASK_1;
		endcase
	endfunction

	function automatic logic [9:0] col_at(input logic [9:0] start, input logic [9:0] beat,
		input logic [9:0] mask, input logic ilv);
		logic [9:0] off;
		off = ilv ? ((start ^ beat) & mask) : (10'(start + beat) & mask);
		return (start & ~mask) | off;
	endfunction

	cmd_t              cmd;
	logic [1:0]        bank;
	logic              rank;
	logic              col_cmd;
	logic [12:0]       row_mask;
	logic              cl3;
	logic              burst_end;
	logic [9:0]        cur_col;
	logic [9:0]        new_mask;
	logic              out_valid;
	logic              mem_we;
	logic [MEM_AW-1:0] mem_addr;
	logic [DQ_W-1:0]   mem_q;

	mode_t             mode_r;
	logic              mode_loaded_r;
	logic [1:0]        refresh_cnt_r;
	logic              dense_r;
	logic [3:0]        open_r;
	logic [12:0]       row_r [0:3];
	burst_t            burst_r;
	logic              active_r;
	logic [9:0]        beat_r;
	logic [DQ_W-1:0]   wdata_r;
	logic [LANES-1:0]  wmask_r;
	logic              rd_v1_r;
	logic              rd_v2_r;
	logic [DQ_W-1:0]   dq3_r;
	logic [LANES-1:0]  mask_d1_r;
	logic [LANES-1:0]  mask_d2_r;
	logic              ap_valid_r;
	logic              ap_write_r;
	logic [7:0]        ap_addr_r;
	logic [31:0]       hrdata_r;
	logic [31:0]       rd_mux;

	// The controller runs on CLOCK, so its pins are sampled directly on each edge.
	assign cmd       = decode_cmd(RANK_SEL_N, RAS_N, CAS_N, WE_N);
	assign bank      = {BANK_SELECT_HI, BANK_SELECT_LO};
	assign rank      = RANK_SEL_N[0];
	assign col_cmd   = (cmd == CMD_READ) || (cmd == CMD_WRITE);
	assign row_mask  = dense_r ? ROW_MASK_LARGE : ROW_MASK_SMALL;
	assign cl3       = (mode_r.read_latency_field == CL_CODE_3);
	assign cur_col   = col_at(burst_r.start, beat_r, burst_r.mask, burst_r.interleave);
	assign burst_end = active_r && !col_cmd && (cmd != CMD_TERMINATE) &&
		(beat_r == burst_r.mask) && (burst_r.mask != COL_MASK_FULL);
	// Writes in single-location mode ignore the programmed length.
	assign new_mask  = (cmd == CMD_WRITE && mode_r.write_single_location_bit) ?
		COL_MASK_1 : len_mask(mode_r.burst_length_field);

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			mode_r        <= '0;
			mode_loaded_r <= 1'b0;
		end else if (cmd == CMD_LMR) begin
			mode_r        <= mode_t'(ADDR[MODE_W-1:0]);
			mode_loaded_r <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			refresh_cnt_r <= '0;
		end else if (cmd == CMD_REFRESH && refresh_cnt_r != REFRESH_MAX) begin
			refresh_cnt_r <= refresh_cnt_r + 2'h1;
		end
	end

	// Banks are tracked independently, so a precharge never disturbs a burst elsewhere.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			open_r <= '0;
			for (int b = 0; b < 4; b++) begin
				row_r[b] <= '0;
			end
		end else begin
			if (burst_end && burst_r.auto_pre) begin
				open_r[burst_r.bank] <= 1'b0;
			end
			if (cmd == CMD_ACTIVE) begin
				open_r[bank] <= 1'b1;
				row_r[bank]  <= ADDR & row_mask;
			end else if (cmd == CMD_PRECHARGE) begin
				if (ADDR[AP_BIT]) begin
					open_r <= '0;
				end else begin
					open_r[bank] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			burst_r  <= '0;
			active_r <= 1'b0;
			beat_r   <= '0;
		end else if (col_cmd) begin
			active_r            <= 1'b1;
			beat_r              <= '0;
			burst_r.is_write    <= (cmd == CMD_WRITE);
			burst_r.auto_pre    <= ADDR[AP_BIT];
			burst_r.rank        <= rank;
			burst_r.bank        <= bank;
			burst_r.start       <= ADDR[COL_W-1:0];
			burst_r.mask        <= new_mask;
			// Full page has no interleaved order; it always counts upward.
			burst_r.interleave  <= mode_r.burst_order_bit && (new_mask != COL_MASK_FULL);
		end else if (cmd == CMD_TERMINATE) begin
			active_r <= 1'b0;
		end else if (burst_end) begin
			active_r <= 1'b0;
		end else if (active_r) begin
			beat_r <= beat_r + 10'h001;
		end
	end

	// Write data taken at edge k belongs to the beat addressed in the following cycle.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			wdata_r <= '0;
			wmask_r <= '0;
		end else begin
			wdata_r <= DQ_IN;
			wmask_r <= BYTE_LANE_MASK;
		end
	end

	assign mem_we   = active_r && burst_r.is_write;
	assign mem_addr = {burst_r.rank, burst_r.bank, row_r[burst_r.bank][MEM_ROW_BITS-1:0], cur_col};

	sdram_array u_array (
		.clock   (CLOCK),
		.rstn    (RSTN),
		.wr_en   (mem_we),
		.byte_en (~wmask_r),
		.addr    (mem_addr),
		.wr_data (wdata_r),
		.rd_data (mem_q)
	);

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rd_v1_r   <= 1'b0;
			rd_v2_r   <= 1'b0;
			dq3_r     <= '0;
			mask_d1_r <= '0;
			mask_d2_r <= '0;
		end else begin
			rd_v1_r   <= active_r && !burst_r.is_write;
			rd_v2_r   <= rd_v1_r;
			dq3_r     <= mem_q;
			mask_d1_r <= BYTE_LANE_MASK;
			mask_d2_r <= mask_d1_r;
		end
	end

	// Latency is a static mode setting, so the select never glitches mid-burst.
	assign out_valid = cl3 ? rd_v2_r : rd_v1_r;
	assign DQ_OUT    = cl3 ? dq3_r : mem_q;
	assign DQ_OE     = {LANES{out_valid}} & ~mask_d2_r;

	// AHB-Lite slave: zero wait states, read data prepared during the address phase.
	always_comb begin
		rd_mux = '0;
		case (HADDR[7:0])
			REG_CONFIG: rd_mux = {31'h0, dense_r};
			REG_MODE:   rd_mux = {19'h0, mode_loaded_r, mode_r};
			REG_STATUS: rd_mux = {24'h0, cl3, refresh_cnt_r, active_r, open_r};
			default:    rd_mux = '0;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ap_valid_r <= 1'b0;
			ap_write_r <= 1'b0;
			ap_addr_r  <= '0;
			hrdata_r   <= '0;
		end else if (HREADY) begin
			ap_valid_r <= HSEL && HTRANS[1];
			ap_write_r <= HWRITE;
			ap_addr_r  <= HADDR[7:0];
			if (HSEL && HTRANS[1] && !HWRITE) begin
				hrdata_r <= rd_mux;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			dense_r <= 1'b0;
		end else if (ap_valid_r && ap_write_r && ap_addr_r == REG_CONFIG) begin
			dense_r <= HWDATA[0];
		end
	end

	assign HRDATA    = hrdata_r;
	assign HREADYOUT = 1'b1;
	assign HRESP     = HRESP_OKAY;

	AST_ACT_ROW: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cmd == CMD_ACTIVE |=> open_r[$past(bank)] &&
		row_r[$past(bank)] == ($past(ADDR) & $past(row_mask)))
		else $error("ACTIVE did not open the bank with the masked row.");

	AST_PRE_ALL: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cmd == CMD_PRECHARGE && ADDR[AP_BIT] |=> open_r == 4'h0)
		else $error("Precharge-all left a bank open.");

	AST_PRE_ONE: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cmd == CMD_PRECHARGE && !ADDR[AP_BIT] |=> !open_r[$past(bank)])
		else $error("Single-bank precharge did not close the bank.");

	AST_LMR: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cmd == CMD_LMR |=> mode_r == mode_t'($past(ADDR[MODE_W-1:0])) && mode_loaded_r)
		else $error("Mode register did not take the load value.");

	AST_MODE_HOLD: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cmd != CMD_LMR |=> $stable(mode_r))
		else $error("Mode register changed without a load command.");

	AST_RANK_IGN: assert property (@(posedge CLOCK) disable iff (!RSTN)
		&RANK_SEL_N && !active_r |=> $stable(open_r) && !active_r)
		else $error("A deselected rank reacted to a command.");

	AST_COL_START: assert property (@(posedge CLOCK) disable iff (!RSTN)
		col_cmd |=> active_r && beat_r == 10'h000 &&
		burst_r.start == $past(ADDR[COL_W-1:0]))
		else $error("Column command did not start a new burst.");

	AST_RD_LAT2: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cmd == CMD_READ && !cl3 ##1 !cl3 |-> ##1 out_valid)
		else $error("Read data not valid two clocks after READ.");

	AST_RD_LAT3: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cmd == CMD_READ && cl3 ##1 cl3[*2] |=> out_valid)
		else $error("Read data not valid three clocks after READ.");

	AST_BL4: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cmd == CMD_READ && new_mask == COL_MASK_4 ##1
		(!col_cmd && cmd != CMD_TERMINATE)[*4] |=> !active_r)
		else $error("Length-four burst did not end after four beats.");

	AST_BLOCK: assert property (@(posedge CLOCK) disable iff (!RSTN)
		active_r |-> ((cur_col ^ burst_r.start) & ~burst_r.mask) == 10'h000)
		else $error("Burst column left its aligned block.");

	AST_SEQ: assert property (@(posedge CLOCK) disable iff (!RSTN)
		active_r && !burst_r.interleave && cmd == CMD_NOP && !burst_end |=>
		cur_col == ((10'($past(cur_col) + 10'h001) & burst_r.mask) |
		(burst_r.start & ~burst_r.mask)))
		else $error("Sequential burst did not step by one within its block.");

	AST_AUTO_PRE: assert property (@(posedge CLOCK) disable iff (!RSTN)
		burst_end && burst_r.auto_pre && cmd != CMD_ACTIVE |=> !open_r[$past(burst_r.bank)])
		else $error("Auto precharge did not close the row at burst end.");

	AST_RD_MASK: assert property (@(posedge CLOCK) disable iff (!RSTN)
		out_valid |-> DQ_OE == ~$past(BYTE_LANE_MASK, 2))
		else $error("Read lane enable does not follow the mask two clocks back.");
endmodule
`default_nettype wire

//--- rtl/sdram_module_pkg.sv
// Shared constants, field layouts and command codes of the SDRAM module model.
`default_nettype none
package sdram_module_pkg;
	localparam int          DQ_W         = 64;
	localparam int          LANES        = 8;
	localparam int          ADDR_W       = 13;
	localparam int          COL_W        = 10;
	localparam int          MODE_W       = 12;
	localparam int          AP_BIT       = 10;
	localparam int          MEM_ROW_BITS = 1;
	localparam int          MEM_AW       = 1 + 2 + MEM_ROW_BITS + COL_W;
	localparam logic [12:0] ROW_MASK_SMALL = 13'h0FFF;
	localparam logic [12:0] ROW_MASK_LARGE = 13'h1FFF;
	localparam logic [2:0]  BL_CODE_1    = 3'h0;
	localparam logic [2:0]  BL_CODE_2    = 3'h1;
	localparam logic [2:0]  BL_CODE_4    = 3'h2;
	localparam logic [2:0]  BL_CODE_8    = 3'h3;
	localparam logic [2:0]  BL_CODE_FULL = 3'h7;
	localparam logic [9:0]  COL_MASK_1   = 10'h000;
	localparam logic [9:0]  COL_MASK_2   = 10'h001;
	localparam logic [9:0]  COL_MASK_4   = 10'h003;
	localparam logic [9:0]  COL_MASK_8   = 10'h007;
	localparam logic [9:0]  COL_MASK_FULL = 10'h3FF;
	localparam logic [2:0]  CL_CODE_3    = 3'h3;
	localparam logic [1:0]  REFRESH_MAX  = 2'h3;
	localparam logic [7:0]  REG_CONFIG   = 8'h00;
	localparam logic [7:0]  REG_MODE     = 8'h04;
	localparam logic [7:0]  REG_STATUS   = 8'h08;
	localparam logic [1:0]  HRESP_OKAY   = 2'h0;

	typedef struct packed {
		logic [1:0] reserved;
		logic       write_single_location_bit;
		logic       operating_mode_hi;
		logic       operating_mode_lo;
		logic [2:0] read_latency_field;
		logic       burst_order_bit;
		logic [2:0] burst_length_field;
	} mode_t;

	typedef struct packed {
		logic       is_write;
		logic       auto_pre;
		logic       rank;
		logic [1:0] bank;
		logic [9:0] start;
		logic [9:0] mask;
		logic       interleave;
	} burst_t;

	typedef enum logic [3:0] {
		CMD_LMR       = 4'h0,
		CMD_REFRESH   = 4'h1,
		CMD_PRECHARGE = 4'h2,
		CMD_ACTIVE    = 4'h3,
		CMD_WRITE     = 4'h4,
		CMD_READ      = 4'h5,
		CMD_TERMINATE = 4'h6,
		CMD_NOP       = 4'h7,
		CMD_INHIBIT   = 4'h8
	} cmd_t;
endpackage
`default_nettype wire

//--- rtl/sdram_array.sv
// Byte-writable storage array with a registered read port.
`default_nettype none
module sdram_array
	import sdram_module_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              wr_en,
	input  wire logic [LANES-1:0]  byte_en,
	input  wire logic [MEM_AW-1:0] addr,
	input  wire logic [DQ_W-1:0]   wr_data,
	output logic      [DQ_W-1:0]   rd_data
);
	logic [DQ_W-1:0] mem [0:(1<<MEM_AW)-1];

	always_ff @(posedge clock) begin
		if (wr_en) begin
			for (int i = 0; i < LANES; i++) begin
				if (byte_en[i]) begin
					mem[addr][i*8 +: 8] <= wr_data[i*8 +: 8];
				end
			end
		end
	end

	// Read data always comes from a register so the output timing is fixed.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[addr];
		end
	end
endmodule
`default_nettype wire

//--- sim/sdram_ctrl_model.sv
// Memory controller model driving the command, address, mask and data pins.
`default_nettype none
module sdram_ctrl_model
	import sdram_module_pkg::*;
(
	input  wire logic              clock,
	output logic      [1:0]        rank_n,
	output logic      [2:0]        cmd_n,
	output logic      [1:0]        bank,
	output logic      [ADDR_W-1:0] addr,
	output logic      [LANES-1:0]  mask,
	output logic      [DQ_W-1:0]   dq
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rank_n = 2'h3;
		cmd_n = 3'h7;
		bank = 2'h0;
		addr = 13'h0000;
		mask = 8'h00;
		dq = 64'h0;
	end
	// Pins change only just after an edge and hold until the next one.
	task automatic issue(input logic [2:0] c, input logic [1:0] r, input logic [1:0] b,
			input logic [12:0] a, input logic [7:0] m, input logic [63:0] d);
		@(posedge clock);
		cmd_n <= c;
		rank_n <= r;
		bank <= b;
		addr <= a;
		mask <= m;
		dq <= d;
	endtask
	// Idle data is inverted every second cycle, since each call reads dq before the previous edge's update lands.
	task automatic idle(input int n);
		repeat (n) issue(3'h7, 2'h2, 2'h0, 13'h0000, 8'h00, ~dq);
	endtask
	task automatic load(input logic [11:0] mode);
		issue(3'h2, 2'h2, 2'h0, 13'h0400, 8'h00, ~dq);
		idle(2);
		issue(3'h0, 2'h2, 2'h0, {1'b0, mode}, 8'h00, ~dq);
		idle(3);
	endtask
	task automatic init(input logic [11:0] mode);
		idle(1000);
		issue(3'h2, 2'h2, 2'h0, 13'h0400, 8'h00, ~dq);
		idle(2);
		repeat (2) begin
			issue(3'h1, 2'h2, 2'h0, 13'h0000, 8'h00, ~dq);
			idle(8);
		end
		load(mode);
	endtask
endmodule
`default_nettype wire

//--- sim/sdram_module_command_protocol_test.sv
// Self-checking bench of the SDRAM module: bursts, masks, bank state and registers.
`default_nettype none
module sdram_module_command_protocol_test
	import sdram_module_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock;
	logic        rstn;
	logic [1:0]  rank_n;
	logic [2:0]  cmd_n;
	logic [1:0]  bank;
	logic [12:0] addr;
	logic [7:0]  mask;
	logic [63:0] dq_in;
	logic [63:0] dq_out;
	logic [7:0]  dq_oe;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [1:0]  hresp;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	int          fail_count;
	int          n_compared;
	logic [63:0] shadow [logic [12:0]];
	logic [1:0]  rsel;
	logic [7:0]  wmask;
	logic [71:0] exp_q [$];

	sdram_ctrl_model ctl (.clock(clock), .rank_n(rank_n), .cmd_n(cmd_n), .bank(bank),
		.addr(addr), .mask(mask), .dq(dq_in));
	sdram_module_command_protocol dut (.CLOCK(clock), .RSTN(rstn), .RANK_SEL_N(rank_n),
		.RAS_N(cmd_n[2]), .CAS_N(cmd_n[1]), .WE_N(cmd_n[0]), .BANK_SELECT_LO(bank[0]),
		.BANK_SELECT_HI(bank[1]), .ADDR(addr), .BYTE_LANE_MASK(mask), .DQ_IN(dq_in),
		.DQ_OUT(dq_out), .DQ_OE(dq_oe), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	function automatic logic [63:0] lanes(logic [7:0] oe);
		logic [63:0] v;
		for (int i = 0; i < 8; i++) v[i*8 +: 8] = {8{oe[i]}};
		return v;
	endfunction
	function automatic logic [9:0] col_at(logic [9:0] s, int k, logic [9:0] cm, logic ilv);
		logic [9:0] o;
		o = ilv ? ((s & cm) ^ 10'(k)) : (((s & cm) + 10'(k)) & cm);
		return (s & ~cm) | o;
	endfunction

	task automatic cmp_beat(input logic [71:0] got, input logic [71:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Each beat the module drives is checked against the oldest note.
	always @(negedge clock) begin
		if (rstn === 1'b1 && dq_oe !== 8'h00) begin
			if (exp_q.size() == 0) cmp_beat({dq_oe, dq_out}, 72'h0);
			else cmp_beat({dq_oe, dq_out & lanes(dq_oe)}, exp_q.pop_front());
		end
	end

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		rd = hrdata;
	endtask
	task automatic open_row(input logic [1:0] b);
		ctl.issue(3'h3, rsel, b, 13'($urandom), 8'h00, ~dq_in);
		ctl.idle(2);
	endtask
	task automatic wr(input logic [1:0] b, input logic [9:0] c, input logic [9:0] cm,
			input logic ilv, input logic ap, input int n);
		logic [63:0] d;
		logic [12:0] key;
		for (int k = 0; k < n; k++) begin
			d = {$urandom, $urandom};
			key = {rsel[0], b, col_at(c, k, cm, ilv)};
			// Masked lanes keep what the array already held, so only known words get masked.
			if (wmask == 8'h00) begin
				shadow[key] = d;
			end else begin
				shadow[key] = (shadow[key] & lanes(wmask)) | (d & ~lanes(wmask));
			end
			ctl.issue(k == 0 ? 3'h4 : 3'h7, rsel, b, {2'h0, ap, c}, wmask, d);
		end
	endtask
	task automatic rd(input logic [1:0] b, input logic [9:0] c, input logic [9:0] cm,
			input logic ilv, input logic [7:0] m, input int n);
		logic [7:0] oe;
		for (int k = 0; k < n; k++) begin
			oe = (k == 0) ? ~m : 8'hFF;
			exp_q.push_back({oe, shadow[{rsel[0], b, col_at(c, k, cm, ilv)}] & lanes(oe)});
		end
		ctl.issue(3'h5, rsel, b, {3'h0, c}, m, ~dq_in);
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		print_verdict();
	end

	initial begin
		logic [31:0] r;
		logic [9:0]  c;
		void'($urandom(31570));
		rstn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		fail_count = 0;
		n_compared = 0;
		rsel = 2'h2;
		wmask = 8'h00;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		ahb(1'b0, 32'h0, 32'h0, r);
		cmp_reg(r, 32'h0);
		ahb(1'b1, 32'h0, 32'h1, r);
		ahb(1'b0, 32'h0, 32'h0, r);
		cmp_reg(r, 32'h1);
		ahb(1'b0, 32'hC, 32'h0, r);
		cmp_reg(r, 32'h0);
		ahb(1'b1, 32'h4, 32'hFFF, r);
		ahb(1'b0, 32'h4, 32'h0, r);
		cmp_reg(r, 32'h0);
		ctl.init(12'h022);
		ahb(1'b0, 32'h8, 32'h0, r);
		cmp_reg(r & 32'h60, 32'h40);
		ahb(1'b0, 32'h4, 32'h0, r);
		cmp_reg(r, 32'h1022);
		open_row(2'h1);
		open_row(2'h2);
		c = 10'($urandom);
		wr(2'h1, c, 10'h3, 1'b0, 1'b0, 4);
		rd(2'h1, c, 10'h3, 1'b0, 8'h81, 4);
		ctl.idle(6);
		rd(2'h1, c, 10'h3, 1'b0, 8'h00, 1);
		rd(2'h1, c ^ 10'h2, 10'h3, 1'b0, 8'h00, 4);
		ctl.idle(6);
		wmask = 8'($urandom);
		wr(2'h1, c, 10'h3, 1'b0, 1'b0, 4);
		wmask = 8'h00;
		rd(2'h1, c, 10'h3, 1'b0, 8'h00, 4);
		ctl.idle(6);
		wr(2'h2, c, 10'h3, 1'b0, 1'b1, 4);
		ctl.idle(3);
		open_row(2'h0);
		rd(2'h1, c, 10'h3, 1'b0, 8'h00, 4);
		ctl.issue(3'h2, 2'h2, 2'h0, 13'h0000, 8'h00, ~dq_in);
		ctl.idle(6);
		ahb(1'b0, 32'h8, 32'h0, r);
		cmp_reg(r & 32'hF, 32'h2);
		ctl.issue(3'h5, 2'h3, 2'h1, {3'h0, c}, 8'h00, ~dq_in);
		ctl.issue(3'h0, 2'h3, 2'h0, 13'h0007, 8'h00, ~dq_in);
		ctl.idle(6);
		ahb(1'b0, 32'h4, 32'h0, r);
		cmp_reg(r, 32'h1022);
		// Single-location writes: the neighbour written first must survive the second write.
		ctl.load(12'h222);
		open_row(2'h1);
		c = 10'($urandom);
		wr(2'h1, col_at(c, 1, 10'h3, 1'b0), 10'h0, 1'b0, 1'b0, 1);
		wr(2'h1, c, 10'h0, 1'b0, 1'b0, 1);
		ctl.idle(4);
		rd(2'h1, col_at(c, 1, 10'h3, 1'b0), 10'h0, 1'b0, 8'h00, 1);
		ctl.issue(3'h6, rsel, 2'h1, 13'h0000, 8'h00, ~dq_in);
		rd(2'h1, c, 10'h0, 1'b0, 8'h00, 1);
		ctl.issue(3'h6, rsel, 2'h1, 13'h0000, 8'h00, ~dq_in);
		ctl.idle(4);
		ctl.load(12'h03B);
		rsel = 2'h1;
		open_row(2'h1);
		c = 10'($urandom);
		wr(2'h1, c, 10'h7, 1'b1, 1'b0, 8);
		rd(2'h1, c, 10'h7, 1'b1, 8'h00, 8);
		ctl.idle(12);
		rsel = 2'h2;
		ahb(1'b0, 32'h8, 32'h0, r);
		cmp_reg(r & 32'h80, 32'h80);
		ctl.load(12'h02F);
		open_row(2'h3);
		wr(2'h3, 10'h3FE, 10'h3FF, 1'b0, 1'b0, 3);
		ctl.issue(3'h6, 2'h2, 2'h3, 13'h0000, 8'h00, ~dq_in);
		rd(2'h3, 10'h3FE, 10'h3FF, 1'b0, 8'h00, 3);
		ctl.idle(2);
		ctl.issue(3'h6, 2'h2, 2'h3, 13'h0000, 8'h00, ~dq_in);
		ctl.idle(8);
		cmp_reg(32'(exp_q.size()), 32'h0);
		cmp_reg({30'h0, hresp}, {30'h0, HRESP_OKAY});
		print_verdict();
	end
endmodule
`default_nettype wire
